// File: rtl/flash_front_pkg.sv
// Constants shared by both ends of the serial flash command front end.
// Assumes a 40 MHz core clock on both ends.
package flash_front_pkg;
  localparam int unsigned CLK_HZ                    = 40000000;
  localparam int unsigned SUPPLY_TO_SELECT_DELAY_US = 70;
  localparam int unsigned POWER_UP_WRITE_DELAY_MS   = 20;
  localparam int unsigned SELECT_DELAY_CYCLES       =
    (SUPPLY_TO_SELECT_DELAY_US * (CLK_HZ / 1000000));
  localparam int unsigned WRITE_DELAY_CYCLES        =
    (POWER_UP_WRITE_DELAY_MS * (CLK_HZ / 1000));
  localparam int unsigned SCK_HALF_CYCLES           = 4;
  localparam int unsigned ADDR_BITS                 = 24;
  localparam int unsigned PAGE_MSB                  = 19;
  localparam int unsigned PAGE_LSB                  = 9;
  localparam int unsigned BYTE_MSB                  = 8;
  localparam logic [7:0]  OP_READ_PAGE              = 8'hd2;
  localparam logic [7:0]  OP_READ_CONT              = 8'he8;
  localparam logic [7:0]  OP_READ_BUF1              = 8'hd4;
  localparam logic [7:0]  OP_READ_BUF2              = 8'hd6;
  localparam logic [7:0]  OP_PAGE_86                = 8'h86;
  localparam logic [7:0]  OP_PAGE_88                = 8'h88;
  localparam logic [7:0]  OP_PAGE_89                = 8'h89;
  localparam logic [7:0]  OP_BUF_87                 = 8'h87;
  localparam logic [7:0]  OP_BUF_D1                 = 8'hd1;
  localparam logic [2:0]  PAGE_DUMMY_BYTES          = 3'h4;
  localparam logic [2:0]  BUF_DUMMY_BYTES           = 3'h1;
  localparam logic        MODE3                     = 1'b1;
  localparam logic        MODE0                     = 1'b0;
endpackage : flash_front_pkg

// File: rtl/flash_link_if.sv
// Serial link between host controller and flash front end.
// Assumes the bench resolves so from so_out and so_oe.
`timescale 1ns/1ps
`default_nettype none
interface flash_link_if;
  logic select_n;
  logic sck;
  logic si;
  logic so_out;
  logic so_oe;
  modport device (input select_n, input sck, input si, output so_out, output so_oe);
  modport host (output select_n, output sck, output si, input so_out, input so_oe);
endinterface : flash_link_if
`default_nettype wire

// File: rtl/pin_sync.sv
// Three-stage pin synchroniser; a change counts when stages two and three agree.
// Assumes a single core clock.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter logic INIT = 1'b1
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Pin
  input  wire logic pin,
  output var  logic level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      level <= INIT;
    else if (s2 == s3)
      level <= s3;
  end
endmodule : pin_sync
`default_nettype wire

// File: rtl/flash_front_dev.sv
// Device end: mode detect, opcode/address capture, field split, dummy count.
// Assumes host honours select and write delays after power-up.
//
// Summary of operation
// - Default to mode 3 after reset
// - Serial output high impedance after reset
// - Instructions start only on select falling edge
// - Sample idle clock on select fall
// - Host waits 70 us before selecting
// - Ignore commands during internal power-on reset
// - Host waits 20 ms before program/erase
// - Enter standby after power-up completes
// - Address: 4 spare, 11 page, 9 byte
// - Dummy bytes: 4 page reads, 1 buffer
// - Page ops use page; buffer ops use byte
`timescale 1ns/1ps
`default_nettype none
module flash_front_dev
  import flash_front_pkg::*;
#(
  parameter int unsigned POR_CYCLES = 16
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Link
  flash_link_if.device link,
  // Decoded command to the array logic
  output var  logic        standby,
  output var  logic        mode,
  output var  logic        cmd_valid,
  output var  logic [7:0]  cmd_opcode,
  output var  logic [10:0] cmd_page,
  output var  logic [8:0]  cmd_byte,
  output var  logic        cmd_use_page,
  output var  logic        cmd_use_byte,
  output var  logic [2:0]  cmd_dummy,
  output var  logic        data_phase,
  // Read data from the array logic
  input  wire logic        out_req,
  input  wire logic [7:0]  out_byte
);
  typedef enum logic [2:0] {
    ST_POR    = 3'b000,
    ST_STBY   = 3'b001,
    ST_OPCODE = 3'b010,
    ST_ADDR   = 3'b011,
    ST_DUMMY  = 3'b100,
    ST_DATA   = 3'b101,
    ST_WAIT   = 3'b110
  } state_e;

  state_e      state;
  logic        sel_n;
  logic        sck_l;
  logic        si_l;
  logic        sel_d;
  logic        sck_d;
  logic [15:0] por_count;
  logic [4:0]  bit_count;
  logic [2:0]  dummy_left;
  logic [31:0] shift;
  logic [7:0]  tx;
  logic [2:0]  next_dummy;
  logic        sel_fall;
  logic        sck_rise;
  logic        sck_fall;

  pin_sync #(.INIT(1'b1)) u_sel (.core_clk(core_clk), .reset(reset), .pin(link.select_n),
                                 .level(sel_n));
  pin_sync #(.INIT(1'b1)) u_sck (.core_clk(core_clk), .reset(reset), .pin(link.sck),
                                 .level(sck_l));
  pin_sync #(.INIT(1'b0)) u_si  (.core_clk(core_clk), .reset(reset), .pin(link.si),
                                 .level(si_l));

  assign sel_fall = sel_d & ~sel_n;
  assign sck_rise = ~sck_d & sck_l;
  assign sck_fall = sck_d & ~sck_l;

  always_comb
  begin
    next_dummy = 3'h0;
    case (shift[7:0])
      OP_READ_PAGE, OP_READ_CONT : next_dummy = PAGE_DUMMY_BYTES;
      OP_READ_BUF1, OP_READ_BUF2 : next_dummy = BUF_DUMMY_BYTES;
      default                    : next_dummy = 3'h0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sel_d <= 1'b1;
      sck_d <= 1'b1;
    end
    else
    begin
      sel_d <= sel_n;
      sck_d <= sck_l;
    end
  end

  // Internal power-on reset hold
  always_ff @(posedge core_clk)
  begin
    if (reset)
      por_count <= 16'h0000;
    else if (state == ST_POR)
      por_count <= por_count + 16'h0001;
  end

  // Mode sampled from idle clock level at each selection outside internal power-on reset
  always_ff @(posedge core_clk)
  begin
    if (reset)
      mode <= MODE3;
    else if (sel_fall && state != ST_POR)
      mode <= sck_l ? MODE3 : MODE0;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state      <= ST_POR;
      bit_count  <= 5'h00;
      shift      <= 32'h0;
      dummy_left <= 3'h0;
      cmd_valid  <= 1'b0;
      cmd_opcode <= 8'h00;
      cmd_page   <= 11'h000;
      cmd_byte   <= 9'h000;
      cmd_use_page <= 1'b0;
      cmd_use_byte <= 1'b0;
      cmd_dummy  <= 3'h0;
    end
    else
    begin
      cmd_valid <= 1'b0;
      case (state)
        ST_POR :
          if (por_count == 16'(POR_CYCLES - 1))
            state <= ST_STBY;
        ST_STBY :
          if (sel_fall)
          begin
            state     <= ST_OPCODE;
            bit_count <= 5'h00;
          end
        ST_OPCODE, ST_ADDR, ST_DUMMY :
          if (sel_n)
            state <= ST_STBY;
          else if (sck_rise)
          begin
            shift     <= {shift[30:0], si_l};
            bit_count <= bit_count + 5'h01;
            if (state == ST_OPCODE && bit_count == 5'd7)
            begin
              cmd_opcode <= {shift[6:0], si_l};
              state      <= ST_ADDR;
              bit_count  <= 5'h00;
            end
            else if (state == ST_ADDR && bit_count == 5'(ADDR_BITS - 1))
            begin
              cmd_page     <= shift[PAGE_MSB - 1:PAGE_LSB - 1];
              cmd_byte     <= {shift[BYTE_MSB - 1:0], si_l};
              cmd_use_page <= (cmd_opcode != OP_BUF_87) && (cmd_opcode != OP_BUF_D1);
              cmd_use_byte <= (cmd_opcode != OP_PAGE_86) && (cmd_opcode != OP_PAGE_88)
                              && (cmd_opcode != OP_PAGE_89);
              shift[7:0]   <= cmd_opcode;
              bit_count    <= 5'h00;
              state        <= ST_DUMMY;
              dummy_left   <= 3'h7;
            end
            else if (state == ST_DUMMY && bit_count == 5'd7)
            begin
              bit_count  <= 5'h00;
              dummy_left <= dummy_left - 3'h1;
              if (dummy_left == 3'h1)
                state <= ST_DATA;
            end
          end
          else if (state == ST_DUMMY && dummy_left == 3'h7)
          begin
            cmd_dummy  <= next_dummy;
            cmd_valid  <= 1'b1;
            dummy_left <= next_dummy;
            if (next_dummy == 3'h0)
              state <= ST_DATA;
          end
        ST_DATA, ST_WAIT :
          if (sel_n)
            state <= ST_STBY;
        default :
          state <= ST_STBY;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      data_phase <= 1'b0;
    else
      data_phase <= (state == ST_DATA) && !sel_n;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      standby <= 1'b0;
    else
      standby <= (state == ST_STBY);
  end

  // Output shifts on falling clock edge; drive only when asked
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      tx          <= 8'h00;
      link.so_out <= 1'b0;
      link.so_oe  <= 1'b0;
    end
    else if (sel_n || state != ST_DATA || !out_req)
    begin
      link.so_oe  <= 1'b0;
      link.so_out <= 1'b0;
      tx          <= out_byte;
    end
    else
    begin
      link.so_oe <= 1'b1;
      if (sck_fall || !link.so_oe)
      begin
        link.so_out <= tx[7];
        tx          <= {tx[6:0], tx[7]};
      end
    end
  end
endmodule : flash_front_dev
`default_nettype wire

// File: rtl/flash_front_host.sv
// Host end: waits power-up delays, then issues opcode, address, dummy bytes.
// Assumes the device end shares the link interface.
`timescale 1ns/1ps
`default_nettype none
module flash_front_host
  import flash_front_pkg::*;
#(
  parameter int unsigned SELECT_WAIT = SELECT_DELAY_CYCLES,
  parameter int unsigned WRITE_WAIT  = WRITE_DELAY_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Link
  flash_link_if.host link,
  // User request
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_mode3,
  input  wire logic [7:0]  req_opcode,
  input  wire logic [10:0] req_page,
  input  wire logic [8:0]  req_byte,
  output var  logic        req_ready,
  output var  logic        write_allowed
);
  logic [19:0] wait_count;
  logic [6:0]  bits_left;
  logic [31:0] tx;
  logic [2:0]  half;
  logic        busy;
  logic        setup;
  logic [6:0]  frame_bits;

  // Reads that return data need trailing dummy bytes before any turnaround
  always_comb
  begin
    frame_bits = 7'h20;
    case (req_opcode)
      OP_READ_PAGE, OP_READ_CONT : frame_bits = 7'h20 + {1'b0, PAGE_DUMMY_BYTES, 3'h0};
      OP_READ_BUF1, OP_READ_BUF2 : frame_bits = 7'h20 + {1'b0, BUF_DUMMY_BYTES, 3'h0};
      default                    : frame_bits = 7'h20;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      wait_count <= 20'h00000;
    else if (wait_count != 20'(WRITE_WAIT))
      wait_count <= wait_count + 20'h00001;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      write_allowed <= 1'b0;
    else
      write_allowed <= (wait_count == 20'(WRITE_WAIT));
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      busy          <= 1'b0;
      req_ready     <= 1'b0;
      link.select_n <= 1'b1;
      link.sck      <= 1'b1;
      link.si       <= 1'b0;
      tx            <= 32'h0;
      bits_left     <= 7'h00;
      half          <= 3'h0;
      setup         <= 1'b0;
    end
    else if (!busy)
    begin
      req_ready <= (wait_count >= 20'(SELECT_WAIT)) && (wait_count >= 20'(WRITE_WAIT)
                   || !req_write);
      link.sck  <= req_mode3;
      if (req_valid && req_ready)
      begin
        busy      <= 1'b1;
        setup     <= 1'b1;
        req_ready <= 1'b0;
        tx        <= {req_opcode, 4'h0, req_page, req_byte};
        bits_left <= frame_bits;
        half      <= 3'h0;
      end
    end
    else if (half != 3'(SCK_HALF_CYCLES - 1))
      half <= half + 3'h1;
    else
    begin
      half <= 3'h0;
      if (setup)
      begin
        // Idle clock level settles a full half period before select falls
        setup         <= 1'b0;
        link.select_n <= 1'b0;
        link.si       <= tx[31];
      end
      else if (!link.sck)
      begin
        link.sck  <= 1'b1;
        tx        <= {tx[30:0], 1'b0};
        bits_left <= bits_left - 7'h01;
      end
      else if (bits_left == 7'h00)
      begin
        link.select_n <= 1'b1;
        busy          <= 1'b0;
      end
      else
      begin
        link.sck <= 1'b0;
        link.si  <= tx[31];
      end
    end
  end
endmodule : flash_front_host
`default_nettype wire

// File: bench/flash_link_sva.sv
// Checker for the serial link between host end and device end.
// Assumes it watches the interface signals in the same core clock domain.
`timescale 1ns/1ps
`default_nettype none
module flash_link_sva
  import flash_front_pkg::*;
#(
  parameter int unsigned SELECT_WAIT = 50
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Link
  input wire logic select_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  logic [15:0] since;
  logic [6:0]  rises;
  logic [7:0]  op;
  logic [6:0]  want;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Saturates so a long run cannot wrap into a false early select
  always_ff @(posedge core_clk)
    since <= reset ? 16'h0 : (&since ? since : since + 16'h1);
  always_ff @(posedge core_clk)
    if (reset || $fell(select_n)) rises <= 7'h0;
    else if (!select_n && $rose(sck)) rises <= rises + 7'h1;
  always_ff @(posedge core_clk)
    if (!select_n && $rose(sck) && rises < 7'h8) op <= {op[6:0], si};
  assign want = (op == OP_READ_PAGE || op == OP_READ_CONT) ? 7'h40 :
                (op == OP_READ_BUF1 || op == OP_READ_BUF2) ? 7'h28 : 7'h20;
  a_oe_off_idle: assert property (select_n && $past(select_n, 5) |-> !so_oe)
    else $error("output driven while deselected");
  a_oe_off_reset: assert property ($fell(reset) |-> !so_oe)
    else $error("output driven after reset");
  a_idle_after_reset: assert property ($fell(reset) |-> select_n && sck)
    else $error("link not idle after reset");
  a_select_wait: assert property ($fell(select_n) |-> since >= SELECT_WAIT - 2)
    else $error("select too early after reset");
  a_sck_steady_fall: assert property ($fell(select_n) |-> $stable(sck))
    else $error("clock moved at select fall");
  a_sck_half_len: assert property (!select_n && $changed(sck)
    |=> (select_n || $stable(sck)) [*3])
    else $error("clock half period too short");
  a_frame_bits: assert property ($rose(select_n) |-> rises == want)
    else $error("wrong clock count in frame");
  a_frame_bounded: assert property ($fell(select_n) |-> ##[200:700] $rose(select_n))
    else $error("frame length out of range");
  a_si_settled: assert property (!select_n && $rose(sck) |-> $stable(si))
    else $error("data moved at sampling edge");
  c_mode3: cover property ($fell(select_n) && sck);
  c_mode0: cover property ($fell(select_n) && !sck);
  c_long: cover property ($rose(select_n) && rises == 7'h40);
endmodule : flash_link_sva
`default_nettype wire

// File: bench/tb.sv
// Bench joining host end and device end, with a queue model of commands.
// Assumes shortened power-up waits set through parameters.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import flash_front_pkg::*;
  localparam int POR = 120;
  logic core_clk = 0, reset = 1, req_valid = 0, req_write = 0, req_mode3 = 1;
  logic [7:0] req_opcode = 8'h0, out_byte = 8'h0;
  logic [10:0] req_page = 11'h0;
  logic [8:0] req_byte = 9'h0;
  logic out_req = 0, req_ready, write_allowed, standby, mode, cmd_valid, cmd_use_page;
  logic cmd_use_byte, data_phase;
  logic [7:0] cmd_opcode;
  logic [10:0] cmd_page;
  logic [8:0] cmd_byte;
  logic [2:0] cmd_dummy;
  logic [28:0] q[$];
  logic [28:0] e;
  logic [7:0] ops[10] = '{8'h86, 8'h87, 8'h88, 8'h89, 8'hd1, 8'hd2, 8'hd4, 8'hd6, 8'he8, 8'h03};
  int cyc = 0, n_mismatch = 0, comparisons = 0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= reset ? 0 : cyc + 1;
  flash_link_if lk();
  flash_front_dev #(.POR_CYCLES(POR)) i_flash_front_dev (.core_clk(core_clk), .reset(reset),
    .link(lk), .standby(standby), .mode(mode), .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode), .cmd_page(cmd_page), .cmd_byte(cmd_byte),
    .cmd_use_page(cmd_use_page), .cmd_use_byte(cmd_use_byte), .cmd_dummy(cmd_dummy),
    .data_phase(data_phase), .out_req(out_req), .out_byte(out_byte));
  flash_front_host #(.SELECT_WAIT(50), .WRITE_WAIT(100)) i_flash_front_host (
    .core_clk(core_clk), .reset(reset), .link(lk), .req_valid(req_valid),
    .req_write(req_write), .req_mode3(req_mode3), .req_opcode(req_opcode),
    .req_page(req_page), .req_byte(req_byte), .req_ready(req_ready),
    .write_allowed(write_allowed));
  flash_link_sva #(.SELECT_WAIT(50)) i_flash_link_sva (.core_clk(core_clk), .reset(reset),
    .select_n(lk.select_n), .sck(lk.sck), .si(lk.si), .so_out(lk.so_out), .so_oe(lk.so_oe));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // Commands taken while the device is still powering up must vanish
  task automatic send(input logic [7:0] op, input logic m3, input logic wr);
    int n;
    n = 0;
    @(negedge core_clk);
    req_valid = 1;
    req_write = wr;
    req_opcode = op;
    req_mode3 = m3;
    req_page = 11'($urandom);
    req_byte = 9'($urandom);
    while (req_ready !== 1'b1 && n < 3000)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(n < 3000, 1);
    if (wr) chk(cyc >= 100, 1);
    if (cyc > POR) q.push_back({m3, op, req_page, req_byte});
    @(posedge core_clk);
    @(negedge core_clk) req_valid = 0;
    repeat (n < 3000 ? 0 : 1) end_of_test();
  endtask : send
  always @(negedge core_clk)
  begin
    out_req <= 1'($urandom);
    out_byte <= 8'($urandom);
  end
  always @(negedge core_clk)
    if (reset === 1'b0 && cmd_valid === 1'b1)
    begin
      chk(q.size() > 0, 1);
      e = q.pop_front();
      chk(mode, e[28]);
      chk(cmd_opcode, e[27:20]);
      if (e[27:20] inside {8'h86, 8'h88, 8'h89})
        chk({cmd_use_page, cmd_use_byte, cmd_page}, {2'b10, e[19:9]});
      else if (e[27:20] inside {8'h87, 8'hd1})
        chk({cmd_use_page, cmd_use_byte, cmd_byte}, {2'b01, e[8:0]});
      else
        chk({cmd_use_page, cmd_use_byte, cmd_page, cmd_byte}, {2'b11, e[19:0]});
      if (e[27:20] inside {8'hd2, 8'he8}) chk(cmd_dummy, 4);
      if (e[27:20] inside {8'hd4, 8'hd6}) chk(cmd_dummy, 1);
      if (!(e[27:20] inside {8'hd2, 8'he8, 8'hd4, 8'hd6})) chk(cmd_dummy, 0);
      @(negedge core_clk) chk(data_phase, e[27:20] inside {8'hd2, 8'he8, 8'hd4, 8'hd6} ? 0 : 1);
    end
  initial
  begin
    void'($urandom(2568));
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) reset = 0;
    #1 chk({mode, lk.so_oe}, 2'b10);
    repeat (40) @(posedge core_clk);
    #1 chk({standby, write_allowed}, 0);
    send(8'hd2, 1'b0, 1'b1);
    repeat (600) @(posedge core_clk);
    #1 chk({standby, write_allowed}, 2'b11);
    for (int i = 0; i < 10; i++) send(ops[i], 1'($urandom), 1'($urandom));
    repeat (800) @(posedge core_clk);
    @(negedge core_clk) reset = 1;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) reset = 0;
    #1 chk({mode, lk.so_oe, standby}, 3'b100);
    repeat (200) @(posedge core_clk);
    send(8'he8, 1'b1, 1'b0);
    repeat (800) @(posedge core_clk);
    chk(q.size(), 0);
    end_of_test();
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule : tb
`default_nettype wire
